// ### src/sfl_consts.svh
// Constants for the status flag and indirect load execute block
// What this block does
// [RQ1] Set-sign op forces sign flag, one cycle
// [RQ2] Clear-sign op zeroes sign flag, one cycle
// [RQ3] Set-overflow op forces overflow flag, one cycle
// [RQ4] Clear-overflow op zeroes overflow flag, one cycle
// [RQ5] Set-half-carry op forces half-carry, one cycle
// [RQ6] Clear-half-carry op zeroes half-carry, one cycle
// [RQ7] Post-increment load: read, then pointer plus one
// [RQ8] Pre-decrement load: pointer minus one, then read
// [RQ9] Flag ops update flags by cycle end
`ifndef SFL_CONSTS_SVH
`define SFL_CONSTS_SVH
// Status flag bit positions
`define SFL_BIT_C 0
`define SFL_BIT_Z 1
`define SFL_BIT_N 2
`define SFL_BIT_V 3
`define SFL_BIT_S 4
`define SFL_BIT_H 5
`define SFL_BIT_T 6
`define SFL_BIT_I 7
// Reset values and pointer step
`define SFL_FLAGS_RST 8'h00
`define SFL_PTR_RST   16'h0000
`define SFL_PTR_ONE   16'h0001
`endif

// ### src/sfl_pkg.sv
// Types shared by the status flag and indirect load execute block
package sfl_pkg;
  // Operation codes delivered by the decoder
  typedef enum logic [3:0] {
    SFL_OP_NONE,
    SFL_OP_SET_SIGN,
    SFL_OP_CLR_SIGN,
    SFL_OP_SET_OVF,
    SFL_OP_CLR_OVF,
    SFL_OP_SET_HALF,
    SFL_OP_CLR_HALF,
    SFL_OP_LD_POSTINC,
    SFL_OP_LD_PREDEC
  } sfl_op_t;

  // Pointer selector
  typedef enum logic [1:0] {
    SFL_PTR_X,
    SFL_PTR_Y,
    SFL_PTR_Z
  } sfl_ptr_sel_t;

  // Decoded instruction handed in by the fetch/decode path
  typedef struct packed {
    sfl_op_t      op;
    sfl_ptr_sel_t ptr;
    logic [4:0]   dst;
  } sfl_instr_t;

  // Register file write produced by a load
  typedef struct packed {
    logic       en;
    logic [4:0] idx;
    logic [7:0] data;
  } sfl_rf_wr_t;

  // Execute states
  typedef enum logic {
    SFL_ST_IDLE,
    SFL_ST_LOAD
  } sfl_state_t;
endpackage

// ### src/sfl_exec.sv
// Execute unit for flag set/clear and indirect pointer loads
`include "sfl_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module sfl_exec
  import sfl_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  // Decoded instruction
  input  wire logic              i_instr_valid,
  input  wire sfl_instr_t        i_instr,
  output logic                   o_instr_ready,
  // Data memory read
  output logic [ADDR_W-1:0]      o_mem_addr,
  output logic                   o_mem_rd,
  input  wire logic [7:0]        i_mem_rdata,
  // Results
  output var sfl_rf_wr_t         o_rf_wr,
  output logic [7:0]             o_flags,
  output logic [ADDR_W-1:0]      o_ptr_x,
  output logic [ADDR_W-1:0]      o_ptr_y,
  output logic [ADDR_W-1:0]      o_ptr_z
);

  // Pointer step and pointer reset value, cut to the bus width
  localparam logic [ADDR_W-1:0] PTR_ONE = ADDR_W'(`SFL_PTR_ONE);
  localparam logic [ADDR_W-1:0] PTR_RST = ADDR_W'(`SFL_PTR_RST);
  // Number of pointer registers held in this block
  localparam int                N_PTR   = 3;

  // Sequencing state
  sfl_state_t            state_r;          // Execute phase
  sfl_state_t            state_nxt;        // Phase for next cycle
  logic [4:0]            dst_r;            // Load target index
  logic [4:0]            dst_nxt;          // Next load target index
  // Status flags
  logic [7:0]            flags_r;          // Flags seen by the core
  logic [7:0]            flags_nxt;        // Flags after this cycle
  // Pointer registers
  logic [ADDR_W-1:0]     ptr_r   [N_PTR];  // X, Y, Z pointers
  logic [ADDR_W-1:0]     ptr_nxt [N_PTR];  // Pointers after update
  // Memory read request
  logic [ADDR_W-1:0]     addr_r;           // Registered read address
  logic [ADDR_W-1:0]     addr_nxt;         // Next read address
  logic                  rd_r;             // One-cycle read strobe
  logic                  rd_nxt;           // Next read strobe
  // Register file write
  sfl_rf_wr_t            wr_r;             // One-cycle write pulse
  sfl_rf_wr_t            wr_nxt;           // Next write pulse
  // Decode helpers
  logic                  take;             // Instruction accepted
  logic                  ptr_ok;           // Selector names a pointer
  logic                  is_postinc;       // Post-increment accepted
  logic                  is_predec;        // Pre-decrement accepted
  logic                  is_load;          // Either load accepted
  logic [ADDR_W-1:0]     cur_ptr;          // Selected pointer, old
  logic [ADDR_W-1:0]     inc_ptr;          // Selected pointer plus one
  logic [ADDR_W-1:0]     dec_ptr;          // Selected pointer minus one

  // Ready only between instructions; a load holds off the next one
  assign o_instr_ready = (state_r == SFL_ST_IDLE);

  // Acceptance and load decode, shared by every state group
  always_comb begin
    take       = i_instr_valid && (state_r == SFL_ST_IDLE);
    // The fourth selector code has no pointer behind it
    ptr_ok     = (i_instr.ptr == SFL_PTR_X) ||
                 (i_instr.ptr == SFL_PTR_Y) ||
                 (i_instr.ptr == SFL_PTR_Z);
    is_postinc = take && (i_instr.op == SFL_OP_LD_POSTINC);
    is_predec  = take && (i_instr.op == SFL_OP_LD_PREDEC);
    is_load    = is_postinc || is_predec;
    // Reads as the reset value rather than unknown on a bad selector
    if (ptr_ok) begin
      cur_ptr = ptr_r[i_instr.ptr];
    end else begin
      cur_ptr = PTR_RST;
    end
    // Both wrap at the ends of the address space, as a counter would
    inc_ptr    = cur_ptr + PTR_ONE;
    dec_ptr    = cur_ptr - PTR_ONE;
  end

  // Flag group: each op touches one bit and leaves the rest alone
  always_comb begin
    flags_nxt = flags_r;
    if (take) begin
      case (i_instr.op)
        SFL_OP_SET_SIGN: flags_nxt[`SFL_BIT_S] = 1'b1; // [RQ1] [RQ9]
        SFL_OP_CLR_SIGN: flags_nxt[`SFL_BIT_S] = 1'b0; // [RQ2] [RQ9]
        SFL_OP_SET_OVF:  flags_nxt[`SFL_BIT_V] = 1'b1; // [RQ3] [RQ9]
        SFL_OP_CLR_OVF:  flags_nxt[`SFL_BIT_V] = 1'b0; // [RQ4] [RQ9]
        SFL_OP_SET_HALF: flags_nxt[`SFL_BIT_H] = 1'b1; // [RQ5] [RQ9]
        SFL_OP_CLR_HALF: flags_nxt[`SFL_BIT_H] = 1'b0; // [RQ6] [RQ9]
        default: begin
          // Loads and no-ops keep every flag
          flags_nxt = flags_r; // [RQ7] [RQ8]
        end
      endcase
    end
  end

  // Flag register; the next instruction already sees the new bit
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      flags_r <= `SFL_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt; // [RQ9]
    end
  end

  // Pointer group: only the selected pointer moves, once per load
  always_comb begin
    ptr_nxt = ptr_r;
    if (ptr_ok && is_postinc) begin
      // Bumped alongside the read of the old address
      ptr_nxt[i_instr.ptr] = inc_ptr; // [RQ7]
    end else if (ptr_ok && is_predec) begin
      // Dropped before its new value is read
      ptr_nxt[i_instr.ptr] = dec_ptr; // [RQ8]
    end
  end

  // Pointer registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ptr_r <= '{default: PTR_RST};
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // Read group: address and strobe leave together from flops
  always_comb begin
    addr_nxt = addr_r;
    rd_nxt   = 1'b0;
    if (is_postinc) begin
      // Old pointer value addresses the byte
      addr_nxt = cur_ptr; // [RQ7]
      rd_nxt   = 1'b1;
    end else if (is_predec) begin
      // Decremented value addresses the byte
      addr_nxt = dec_ptr; // [RQ8]
      rd_nxt   = 1'b1;
    end
  end

  // Read request registers; address held between loads
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      addr_r <= PTR_RST;
      rd_r   <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      rd_r   <= rd_nxt;
    end
  end

  // Sequencer group: two-cycle loads, write pulse out the cycle after the second
  always_comb begin
    state_nxt = state_r;
    dst_nxt   = dst_r;
    wr_nxt    = '0;
    case (state_r)
      SFL_ST_IDLE: begin
        // Flag ops finish here; loads move on to the data cycle
        if (is_load) begin
          dst_nxt   = i_instr.dst;
          state_nxt = SFL_ST_LOAD;
        end
      end
      SFL_ST_LOAD: begin
        // Memory answers combinationally; no wait states supported
        wr_nxt.en   = 1'b1; // [RQ7] [RQ8]
        wr_nxt.idx  = dst_r;
        wr_nxt.data = i_mem_rdata;
        state_nxt   = SFL_ST_IDLE;
      end
      default: begin
        // Recover to idle from any stray encoding
        state_nxt = SFL_ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_r <= SFL_ST_IDLE;
      dst_r   <= '0;
      wr_r    <= '0;
    end else begin
      state_r <= state_nxt;
      dst_r   <= dst_nxt;
      wr_r    <= wr_nxt;
    end
  end

  // Outputs straight from flops
  assign o_mem_addr = addr_r;
  assign o_mem_rd   = rd_r;
  assign o_rf_wr    = wr_r;
  assign o_flags    = flags_r;
  assign o_ptr_x    = ptr_r[SFL_PTR_X];
  assign o_ptr_y    = ptr_r[SFL_PTR_Y];
  assign o_ptr_z    = ptr_r[SFL_PTR_Z];

endmodule
`default_nettype wire

// ### test/sfl_exec_properties.sv
// Timing checks on the flag and load execute unit
`timescale 1ns/100ps
`default_nettype none
module sfl_exec_properties
  import sfl_pkg::*;
#(parameter int ADDR_W = 16) (
  // Watched ports
  input wire logic              i_clk,
  input wire logic              i_nrst,
  input wire logic              i_instr_valid,
  input wire sfl_instr_t        i_instr,
  input wire logic              o_instr_ready,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic              o_mem_rd,
  input wire sfl_rf_wr_t        o_rf_wr,
  input wire logic [7:0]        o_flags,
  input wire logic [ADDR_W-1:0] o_ptr_x
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Request taken this edge
  wire logic tk = i_instr_valid && o_instr_ready;
  wire logic lx = tk && i_instr.ptr == SFL_PTR_X;
  // One flag moves, all others hold, next cycle
  property p_fl(sfl_op_t c, logic [7:0] m, logic s);
    tk && i_instr.op == c |=> o_flags ==
      (s ? $past(o_flags) | m : $past(o_flags) & ~m);
  endproperty
  chk_sign_set: assert property (p_fl(SFL_OP_SET_SIGN, 8'h10, 1))
    else $error("sign set");
  chk_sign_clr: assert property (p_fl(SFL_OP_CLR_SIGN, 8'h10, 0))
    else $error("sign clear");
  chk_ovf_set: assert property (p_fl(SFL_OP_SET_OVF, 8'h08, 1))
    else $error("ovf set");
  chk_ovf_clr: assert property (p_fl(SFL_OP_CLR_OVF, 8'h08, 0))
    else $error("ovf clear");
  chk_half_set: assert property (p_fl(SFL_OP_SET_HALF, 8'h20, 1))
    else $error("half set");
  chk_half_clr: assert property (p_fl(SFL_OP_CLR_HALF, 8'h20, 0))
    else $error("half clear");
  // Old pointer read and bumped in the same cycle; write follows
  chk_post_inc: assert property (lx && i_instr.op == SFL_OP_LD_POSTINC
    |=> o_mem_rd && o_mem_addr == $past(o_ptr_x) && $stable(o_flags)
    && o_ptr_x == $past(o_ptr_x) + 1'b1 ##1 o_rf_wr.en) else $error("inc");
  // Pointer dropped first and that address read
  chk_pre_dec: assert property (lx && i_instr.op == SFL_OP_LD_PREDEC
    |=> o_mem_rd && o_mem_addr == o_ptr_x && $stable(o_flags)
    && o_ptr_x == $past(o_ptr_x) - 1'b1 ##1 o_rf_wr.en) else $error("dec");
  cover property (tk && i_instr.op == SFL_OP_SET_HALF);
  cover property (lx && i_instr.op == SFL_OP_LD_POSTINC);
  cover property (lx && i_instr.op == SFL_OP_LD_PREDEC);
endmodule
`default_nettype wire

// ### test/test_sfl_exec.sv
// Self-checking bench for the flag and load execute unit
`timescale 1ns/100ps
`default_nettype none
module test_sfl_exec;
  import sfl_pkg::*;
  logic       i_clk = 0, i_nrst = 0, i_instr_valid = 0;
  logic       o_instr_ready, o_mem_rd;
  sfl_instr_t i_instr = '0;
  logic [7:0] i_mem_rdata = 8'h00, o_flags;
  logic [15:0] o_mem_addr, o_ptr_x, o_ptr_y, o_ptr_z;
  sfl_rf_wr_t o_rf_wr;
  int         bad_count = 0, n_checks = 0, cyc = 0;
  sfl_exec i_sfl_exec (.*);
  initial forever #10 i_clk = ~i_clk;
  // Hang guard, far above the few dozen cycles used
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 400) begin
      bad_count++;
      conclude;
    end
  end
  task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Six flag ops back to back, each seen the next cycle
  task automatic t_flags;
    sfl_op_t ops[6] = '{SFL_OP_SET_SIGN, SFL_OP_SET_OVF, SFL_OP_SET_HALF,
      SFL_OP_CLR_SIGN, SFL_OP_CLR_OVF, SFL_OP_CLR_HALF};
    logic [7:0] ex[6] = '{8'h10, 8'h18, 8'h38, 8'h28, 8'h20, 8'h00};
    for (int i = 0; i <= 6; i++) begin
      @(posedge i_clk);
      i_instr_valid <= i < 6;
      i_instr.op <= ops[i % 6];
      #1 if (i > 0)
        chk("flags", ex[i-1], o_flags);
    end
    $display("flag ops done");
  endtask
  // One load; data driven only in its read cycle
  // With hold set, a flag op waits during the load and must be refused
  task automatic t_ld(sfl_op_t op, sfl_ptr_sel_t p, logic [15:0] ea, ep,
                      bit hold = 0);
    logic [7:0] d = ea[7:0] ^ 8'h5a;
    @(posedge i_clk);
    i_instr_valid <= 1;
    i_instr <= '{op, p, 5'(p) + 5'h3};
    @(posedge i_clk);
    i_instr_valid <= hold;
    if (hold) i_instr.op <= SFL_OP_SET_SIGN;
    i_mem_rdata <= d;
    #1 chk("busy", 1'b0, o_instr_ready);
    #1 chk("read", {1'b1, ea, ep}, {o_mem_rd, o_mem_addr,
      p[1] ? o_ptr_z : p[0] ? o_ptr_y : o_ptr_x});
    @(posedge i_clk);
    i_mem_rdata <= ~d;
    i_instr_valid <= 0;
    #1 chk("write", {1'b1, 5'(p) + 5'h3, d, 8'h00}, {o_rf_wr, o_flags});
    chk("ready", 1'b1, o_instr_ready);
    $display("load done");
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_nrst <= 1;
    #1 chk("reset", {1'b1, 8'h00, 16'h0000}, {o_instr_ready, o_flags, o_ptr_y});
    t_flags;
    t_ld(SFL_OP_LD_POSTINC, SFL_PTR_X, 16'h0000, 16'h0001);
    t_ld(SFL_OP_LD_POSTINC, SFL_PTR_X, 16'h0001, 16'h0002);
    t_ld(SFL_OP_LD_PREDEC, SFL_PTR_X, 16'h0001, 16'h0001);
    t_ld(SFL_OP_LD_PREDEC, SFL_PTR_Z, 16'hffff, 16'hffff);
    t_ld(SFL_OP_LD_POSTINC, SFL_PTR_Y, 16'h0000, 16'h0001, 1);
    conclude;
  end
endmodule
bind sfl_exec sfl_exec_properties #(.ADDR_W(ADDR_W))
  i_sfl_exec_properties (.*);
`default_nettype wire
